/* hw/tv_if_serial_pkg.sv */
// Constants, field positions and state codes for the TV IF serial control slave
// Behaviour
// [RL1] SDA fall with SCL high starts transfer
// [RL2] SDA rise with SCL high ends transfer
// [RL3] SDA changes only while SCL low
// [RL4] Eight bits MSB first, then acknowledge slot
// [RL5] Address byte matches C0H in bits 7..1, either direction
// [RL6] Address LSB one reads, zero writes
// [RL7] Pull SDA low on ninth clock
// [RL8] Wrong address leaves SDA released
// [RL9] Master sends start, address, sub-address, data, stop
// [RL10] First data at sub-address, then auto-increment
// [RL11] Beyond 02H: no store, no ack, release
// [RL12] Read: ack address, send status, then release
// [RL13] Three write registers, one read register
// [RL14] Master clocks SCL; device samples with it
// [RL15] Register 00H bits 7..4 drive four switches
// [RL16] Register 00H bits 3..1 select sound paths
// [RL17] Register 01H: tuning disable, gain response, level
// [RL18] Register 02H bits 5..0 set RF reference
// [RL19] Status: power-on, horizontal, PLL flags, ones below
// [RL20] Synchronise and deglitch SCL and SDA first
package tv_if_serial_pkg;

    // **********************
    // Clock and filter timing
    // **********************
    localparam int CLK_MHZ       = 40;   // System clock rate
    localparam int FILTER_NS     = 50;   // Shortest pulse taken as real
    localparam int FILTER_CYCLES = (FILTER_NS * CLK_MHZ + 999) / 1000;

    // **********************
    // Bus framing
    // **********************
    localparam logic [7:0] SLAVE_ADDR    = 8'hc0; // Write form of address
    localparam int         RW_BIT        = 0;     // Direction bit position
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;  // Data bits per byte
    localparam logic [3:0] FIRST_BIT     = 4'h1;  // Count after first bit
    localparam logic [7:0] SUB_MAX       = 8'h02; // Highest sub-address
    localparam logic [7:0] SUB_STEP      = 8'h01; // Auto-increment step
    localparam int         NUM_CTRL      = 3;     // Writable registers

    // **********************
    // Register offsets and reset values
    // **********************
    localparam logic [7:0] STANDARD_AND_SWITCH_CONTROL = 8'h00;
    localparam logic [7:0] TUNING_GAIN_AND_VIDEO_LEVEL = 8'h01;
    localparam logic [7:0] RF_GAIN_REFERENCE_LEVEL     = 8'h02;
    localparam logic [7:0] CTRL_RESET                  = 8'h00;

    // **********************
    // Field positions
    // **********************
    localparam int TUNE_POL_BIT    = 7;  // Register 00H
    localparam int VIDEO_POL_BIT   = 6;
    localparam int OSC_RANGE_BIT   = 5;
    localparam int GAIN_TYPE_BIT   = 4;
    localparam int SOUND_OUT_BIT   = 3;
    localparam int SOUND_IN_BIT    = 2;
    localparam int SOUND_TRAP_BIT  = 1;
    localparam int TUNE_DIS_BIT    = 7;  // Register 01H
    localparam int GAIN_RESP_BIT   = 6;
    localparam int LEVEL_MSB       = 5;  // Level fields in 01H and 02H
    localparam int STAT_POWER_BIT  = 7;  // Status byte
    localparam int STAT_HLOCK_BIT  = 6;
    localparam int STAT_PLL_BIT    = 5;
    localparam logic [4:0] STATUS_FILL = 5'h1f; // Bits 4..0 read as one

    // **********************
    // Protocol states, one-hot
    // **********************
    typedef enum logic [8:0] {
        ST_IDLE     = 9'h001,
        ST_ADDR     = 9'h002,
        ST_ADDR_ACK = 9'h004,
        ST_SUB      = 9'h008,
        ST_SUB_ACK  = 9'h010,
        ST_DATA     = 9'h020,
        ST_DATA_ACK = 9'h040,
        ST_READ     = 9'h080,
        ST_UNUSED   = 9'h100
    } state_type;

endpackage

/* hw/line_filter.sv */
// Two-flop synchroniser and glitch filter for a group of asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module line_filter #(
    parameter int         WIDTH      = 4,
    parameter int         CYCLES     = 2,
    parameter logic [3:0] RESET_BITS = 4'hf
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Raw and cleaned levels
    input  wire logic [WIDTH-1:0] raw,
    output logic      [WIDTH-1:0] clean
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(CYCLES - 1);
    localparam logic [CW-1:0] CNT_ZERO = '0;
    localparam logic [CW-1:0] CNT_ONE  = CW'(1);

    logic [WIDTH-1:0] sync1_reg;           // First stage, read by second only
    logic [WIDTH-1:0] sync2_reg;           // Second stage
    logic [WIDTH-1:0] clean_reg;           // Accepted level
    logic [WIDTH-1:0] clean_next;
    logic [CW-1:0]    cnt_reg  [WIDTH];    // Cycles the new level has held
    logic [CW-1:0]    cnt_next [WIDTH];

    // ****************************************************************
    // Accept a level only after it holds for CYCLES clocks
    // ****************************************************************
    always_comb begin
        clean_next = clean_reg;
        for (int i = 0; i < WIDTH; i++) begin
            cnt_next[i] = CNT_ZERO;
            if (sync2_reg[i] != clean_reg[i]) begin
                if (cnt_reg[i] == CNT_LAST) begin
                    clean_next[i] = sync2_reg[i]; // Held long enough
                end else begin
                    cnt_next[i] = cnt_reg[i] + CNT_ONE;
                end
            end
        end
    end

    // Register stages
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= RESET_BITS[WIDTH-1:0];
            sync2_reg <= RESET_BITS[WIDTH-1:0];
            clean_reg <= RESET_BITS[WIDTH-1:0];
            for (int i = 0; i < WIDTH; i++) begin
                cnt_reg[i] <= CNT_ZERO;
            end
        end else begin
            sync1_reg <= raw;
            sync2_reg <= sync1_reg;
            clean_reg <= clean_next;
            for (int i = 0; i < WIDTH; i++) begin
                cnt_reg[i] <= cnt_next[i];
            end
        end
    end

    assign clean = clean_reg;

endmodule // line_filter
`default_nettype wire

/* hw/tv_if_control_serial_slave.sv */
// Two-wire serial slave holding the control registers and status byte
`timescale 1ns/1ps
`default_nettype none
module tv_if_control_serial_slave #(
    parameter int FILTER_LEN = tv_if_serial_pkg::FILTER_CYCLES
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Serial bus pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    // Analog status inputs
    input  wire logic       horizontal_unlock_in,
    input  wire logic       pll_unlock_in,
    // Register 00H switches
    output logic            tuning_error_polarity,
    output logic            video_polarity_select,
    output logic            oscillator_range,
    output logic            gain_control_type,
    output logic            sound_output_select,
    output logic            sound_if_input_select,
    output logic            sound_trap_select,
    // Register 01H and 02H fields
    output logic            tuning_output_disable,
    output logic            gain_response_select,
    output logic [5:0]      video_level,
    output logic [5:0]      rf_gain_reference,
    // Status
    output logic            power_on_flag
);
    import tv_if_serial_pkg::*;

    // **********************
    // Declarations
    // **********************
    logic [3:0] filt;                         // Clean scl, sda, hlock, pll
    logic       scl_f;                        // Filtered clock
    logic       sda_f;                        // Filtered data
    logic       scl_prev_reg;                 // Clock one cycle ago
    logic       sda_prev_reg;                 // Data one cycle ago
    logic       scl_rise;                     // Clock rising edge
    logic       scl_fall;                     // Clock falling edge
    logic       start_det;                    // Start condition seen
    logic       stop_det;                     // Stop condition seen
    state_type  state_reg;                    // Protocol state
    state_type  state_next;
    logic [3:0] cnt_reg;                      // Bits shifted this byte
    logic [3:0] cnt_next;
    logic [7:0] shift_reg;                    // Byte in or out
    logic [7:0] shift_next;
    logic [7:0] sub_reg;                      // Current sub-address
    logic [7:0] sub_next;
    logic       read_reg;                     // Direction of transfer
    logic       read_next;
    logic       oe_n_reg;                     // Pin release, low drives
    logic       oe_n_next;
    logic       por_reg;                      // Power-on flag
    logic       por_next;
    logic [7:0] ctrl_reg  [NUM_CTRL];         // Control registers
    logic [7:0] ctrl_next [NUM_CTRL];
    logic       out_low_reg;                  // Level driven when enabled

    // **********************
    // Input synchronisation and deglitching
    // **********************
    line_filter #(
        .WIDTH      (4),
        .CYCLES     (FILTER_LEN),
        .RESET_BITS (4'hf)
    ) u_filter (
        .clk   (clk),
        .rst   (rst),
        .raw   ({pll_unlock_in, horizontal_unlock_in, sda_in, scl_in}),
        .clean (filt)
    ); // RL20

    assign scl_f = filt[0];
    assign sda_f = filt[1];

    // **********************
    // Bus event detection
    // **********************
    assign scl_rise  = scl_f & ~scl_prev_reg;
    assign scl_fall  = ~scl_f & scl_prev_reg;
    assign start_det = scl_f & scl_prev_reg & sda_prev_reg & ~sda_f; // RL1
    assign stop_det  = scl_f & scl_prev_reg & ~sda_prev_reg & sda_f; // RL2

    // Assemble the status byte from live inputs
    function automatic logic [7:0] status_byte(input logic por, input logic hl, input logic pl);
        logic [7:0] b;
        b                 = {3'h0, STATUS_FILL};
        b[STAT_POWER_BIT] = por;
        b[STAT_HLOCK_BIT] = hl;
        b[STAT_PLL_BIT]   = pl;
        return b; // RL19
    endfunction

    // **********************
    // Protocol next-state logic
    // **********************
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        shift_next = shift_reg;
        sub_next   = sub_reg;
        read_next  = read_reg;
        oe_n_next  = oe_n_reg;
        por_next   = por_reg;
        for (int i = 0; i < NUM_CTRL; i++) begin
            ctrl_next[i] = ctrl_reg[i];
        end
        if (stop_det) begin
            // End any transfer and let go of the line
            state_next = ST_IDLE; // RL2
            oe_n_next  = 1'b1;
        end else if (start_det) begin
            // New transfer begins with the address byte
            state_next = ST_ADDR; // RL1
            cnt_next   = 4'h0;
            oe_n_next  = 1'b1;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    oe_n_next = 1'b1;
                end
                ST_ADDR, ST_SUB, ST_DATA: begin
                    if (scl_rise) begin
                        // Sample on the high phase, MSB first
                        shift_next = {shift_reg[6:0], sda_f}; // RL4 RL14
                        cnt_next   = cnt_reg + FIRST_BIT;
                    end else if (scl_fall && cnt_reg == BITS_PER_BYTE) begin
                        cnt_next = 4'h0;
                        if (state_reg == ST_ADDR) begin
                            if (shift_reg[7:1] == SLAVE_ADDR[7:1]) begin // RL5
                                read_next  = shift_reg[RW_BIT]; // RL6
                                oe_n_next  = 1'b0; // RL7
                                state_next = ST_ADDR_ACK;
                            end else begin
                                state_next = ST_IDLE; // RL8
                            end
                        end else if (state_reg == ST_SUB) begin
                            sub_next   = shift_reg;
                            oe_n_next  = 1'b0; // RL7
                            state_next = ST_SUB_ACK;
                        end else if (sub_reg <= SUB_MAX) begin
                            // Store and step to the next sub-address
                            ctrl_next[sub_reg[1:0]] = shift_reg; // RL10 RL13
                            sub_next   = sub_reg + SUB_STEP; // RL10
                            oe_n_next  = 1'b0; // RL7
                            state_next = ST_DATA_ACK;
                        end else begin
                            // Past the last register: no store, no ack
                            state_next = ST_IDLE; // RL11
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (read_reg) begin
                            // Load status and present its MSB
                            shift_next = status_byte(por_reg, filt[2], filt[3]); // RL12
                            oe_n_next  = shift_next[7]; // RL3
                            cnt_next   = FIRST_BIT;
                            por_next   = 1'b0;
                            state_next = ST_READ;
                        end else begin
                            oe_n_next  = 1'b1; // RL3
                            state_next = ST_SUB;
                        end
                    end
                end
                ST_SUB_ACK, ST_DATA_ACK: begin
                    if (scl_fall) begin
                        oe_n_next  = 1'b1; // RL3
                        state_next = ST_DATA;
                    end
                end
                ST_READ: begin
                    if (scl_fall) begin
                        if (cnt_reg == BITS_PER_BYTE) begin
                            // Byte done: release for the master's slot
                            oe_n_next  = 1'b1; // RL12
                            state_next = ST_IDLE;
                        end else begin
                            oe_n_next  = shift_reg[6]; // RL3 RL4
                            shift_next = {shift_reg[6:0], 1'b1};
                            cnt_next   = cnt_reg + FIRST_BIT;
                        end
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                    oe_n_next  = 1'b1;
                end
            endcase
        end
    end

    // **********************
    // State registers
    // **********************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
            state_reg    <= ST_IDLE;
            cnt_reg      <= 4'h0;
            shift_reg    <= 8'h00;
            sub_reg      <= STANDARD_AND_SWITCH_CONTROL;
            read_reg     <= 1'b0;
            oe_n_reg     <= 1'b1;
            por_reg      <= 1'b1;
            out_low_reg  <= 1'b0;
            for (int i = 0; i < NUM_CTRL; i++) begin
                ctrl_reg[i] <= CTRL_RESET;
            end
        end else begin
            scl_prev_reg <= scl_f;
            sda_prev_reg <= sda_f;
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            shift_reg    <= shift_next;
            sub_reg      <= sub_next;
            read_reg     <= read_next;
            oe_n_reg     <= oe_n_next;
            por_reg      <= por_next;
            out_low_reg  <= 1'b0;
            for (int i = 0; i < NUM_CTRL; i++) begin
                ctrl_reg[i] <= ctrl_next[i];
            end
        end
    end

    // **********************
    // Outputs, all taken from registers
    // **********************
    assign sda_out  = out_low_reg;
    assign sda_oe_n = oe_n_reg;

    // Register 00H switches
    assign tuning_error_polarity = ctrl_reg[0][TUNE_POL_BIT];   // RL15
    assign video_polarity_select = ctrl_reg[0][VIDEO_POL_BIT];  // RL15
    assign oscillator_range      = ctrl_reg[0][OSC_RANGE_BIT];  // RL15
    assign gain_control_type     = ctrl_reg[0][GAIN_TYPE_BIT];  // RL15
    assign sound_output_select   = ctrl_reg[0][SOUND_OUT_BIT];  // RL16
    assign sound_if_input_select = ctrl_reg[0][SOUND_IN_BIT];   // RL16
    assign sound_trap_select     = ctrl_reg[0][SOUND_TRAP_BIT]; // RL16

    // Register 01H and 02H fields
    assign tuning_output_disable = ctrl_reg[1][TUNE_DIS_BIT];   // RL17
    assign gain_response_select  = ctrl_reg[1][GAIN_RESP_BIT];  // RL17
    assign video_level           = ctrl_reg[1][LEVEL_MSB:0];    // RL17
    assign rf_gain_reference     = ctrl_reg[2][LEVEL_MSB:0];    // RL18

    assign power_on_flag = por_reg;

endmodule // tv_if_control_serial_slave
`default_nettype wire

/* testbench/tv_if_slave_checker.sv */
// Assertion checker for the TV IF serial control slave
`timescale 1ns/1ps
`default_nettype none
module tv_if_slave_checker #(
    parameter int FILTER_LEN = 2
) (
    // Clock, reset and bus pins
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe_n,
    // Register outputs
    input wire logic       tuning_error_polarity,
    input wire logic [5:0] video_level,
    input wire logic [5:0] rf_gain_reference,
    input wire logic       power_on_flag
);
    // **********************
    // Properties
    // **********************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [5:0] low_cnt_reg;   // Clocks SDA held low
    logic [5:0] low_cnt_next;  // Next count
    // Count consecutive low-drive clocks
    always_comb begin
        low_cnt_next = sda_oe_n ? 6'h00 : low_cnt_reg + 6'h01;
    end
    // Register the count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_cnt_reg <= 6'h00;
        end else begin
            low_cnt_reg <= low_cnt_next;
        end
    end
    // SDA rises while SCL stays high
    sequence s_stop;
        scl_in && $past(scl_in) && $rose(sda_in);
    endsequence
    // Line left alone for eight clocks
    sequence s_released;
        sda_oe_n [*8];
    endsequence
    property p_open_drain; !sda_oe_n |-> !sda_out; endproperty
    property p_change_low; $changed(sda_oe_n) |-> !scl_in; endproperty
    property p_stop_release; s_stop |-> ##[0:8] s_released; endproperty
    property p_reset_state; $past(rst) |-> power_on_flag && sda_oe_n && video_level == 6'h00; endproperty
    property p_flag_no_set; $rose(power_on_flag) |-> $past(rst); endproperty
    property p_store_ack; $changed({tuning_error_polarity, video_level, rf_gain_reference}) |-> !sda_oe_n; endproperty
    property p_ack_hold; $fell(sda_oe_n) |-> !sda_oe_n [*8]; endproperty
    property p_low_bound; low_cnt_reg <= 6'h20; endproperty
    a_open_drain: assert property (p_open_drain) else $error("SDA driven high");
    a_change_low: assert property (p_change_low) else $error("SDA moved with SCL high");
    a_stop_release: assert property (p_stop_release) else $error("SDA held after stop");
    a_reset_state: assert property (p_reset_state) else $error("Bad state after reset");
    a_flag_no_set: assert property (p_flag_no_set) else $error("Power flag set outside reset");
    a_store_ack: assert property (p_store_ack) else $error("Register stored without ack");
    a_ack_hold: assert property (p_ack_hold) else $error("Low drive shorter than a bit");
    a_low_bound: assert property (p_low_bound) else $error("SDA held low too long");
endmodule // tv_if_slave_checker
bind tv_if_control_serial_slave tv_if_slave_checker #(.FILTER_LEN(FILTER_LEN)) tv_if_slave_checker_i (
    .clk, .rst, .scl_in, .sda_in, .sda_out, .sda_oe_n,
    .tuning_error_polarity, .video_level, .rf_gain_reference, .power_on_flag
);
`default_nettype wire

/* testbench/tv_if_bus_master.sv */
// Behavioural master that clocks the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module tv_if_bus_master (
    // Clock and resolved data line
    input  wire logic clk,
    input  wire logic sda_wire,
    // Open-drain drives, 1 releases
    output var logic  scl_drv,
    output var logic  sda_drv
);
    // **********************
    // Bus cycles
    // **********************
    // Idle bus at time zero
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end
    // Wait falling clock edges
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Start, also as a repeated start
    task automatic bus_start();
        wait_n(2);
        sda_drv = 1'b1;
        wait_n(3);
        scl_drv = 1'b1;
        wait_n(4);
        sda_drv = 1'b0;
        wait_n(4);
        scl_drv = 1'b0;
    endtask
    // Stop, then idle long enough to settle
    task automatic bus_stop();
        wait_n(2);
        sda_drv = 1'b0;
        wait_n(3);
        scl_drv = 1'b1;
        wait_n(4);
        sda_drv = 1'b1;
        wait_n(10);
    endtask
    // One bit: 125 ns low, 75 ns high
    task automatic bit_io(input logic v, output logic s);
        wait_n(2);
        sda_drv = v;
        wait_n(3);
        scl_drv = 1'b1;
        wait_n(3);
        s = sda_wire;
        scl_drv = 1'b0;
    endtask
    // First n bits of a byte, then the ack slot for a whole one
    task automatic put_byte(input logic [7:0] b, input int n, output logic ack);
        logic s;
        for (int i = 0; i < n; i++) begin
            bit_io(b[7-i], s);
        end
        ack = 1'b0;
        if (n == 8) begin
            bit_io(1'b1, s);
            ack = !s;
        end
    endtask
    // Read a byte, answer with no ack, report the line level
    task automatic get_byte(output logic [7:0] b, output logic rel);
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, b[i]);
        end
        bit_io(1'b1, rel);
    endtask
endmodule // tv_if_bus_master
`default_nettype wire

/* testbench/tv_if_control_serial_slave_tb.sv */
// Self-checking testbench for the TV IF serial control slave
`timescale 1ns/1ps
`default_nettype none
module tv_if_control_serial_slave_tb;
    import tv_if_serial_pkg::*;
    // **********************
    // Signals and instances
    // **********************
    localparam int FLT   = 1;      // Short filter for a 200 ns bus clock
    localparam int LIMIT = 20000;  // Cycle ceiling
    logic       clk                  = 1'b0;
    logic       rst                  = 1'b1;
    logic       horizontal_unlock_in = 1'b0;
    logic       pll_unlock_in        = 1'b0;
    logic       scl_in, sda_in, sda_drv, sda_out, sda_oe_n, power_on_flag;
    logic       tuning_error_polarity, video_polarity_select, oscillator_range, gain_control_type;
    logic       sound_output_select, sound_if_input_select, sound_trap_select;
    logic       tuning_output_disable, gain_response_select;
    logic [5:0] video_level, rf_gain_reference;
    int         error_cnt  = 0;
    int         num_checks = 0;
    int         cycles     = 0;
    // Open-drain data line with pull-up
    assign sda_in = sda_drv & (sda_oe_n | sda_out);
    tv_if_control_serial_slave #(.FILTER_LEN(FLT)) tv_if_control_serial_slave_i (
        .clk, .rst, .scl_in, .sda_in, .sda_out, .sda_oe_n, .horizontal_unlock_in, .pll_unlock_in,
        .tuning_error_polarity, .video_polarity_select, .oscillator_range, .gain_control_type,
        .sound_output_select, .sound_if_input_select, .sound_trap_select, .tuning_output_disable,
        .gain_response_select, .video_level, .rf_gain_reference, .power_on_flag);
    tv_if_bus_master tv_if_bus_master_i (.clk(clk), .sda_wire(sda_in), .scl_drv(scl_in), .sda_drv(sda_drv));
    always #12.5 clk = ~clk;
    // Cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            error_cnt++;
            conclude();
        end
    end
    // Report and end the run
    task automatic conclude();
        $display("Checks %0d, errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Compare and count
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Output views of the three control registers
    function automatic logic [7:0] r00();
        return {tuning_error_polarity, video_polarity_select, oscillator_range, gain_control_type,
                sound_output_select, sound_if_input_select, sound_trap_select, 1'b0};
    endfunction
    function automatic logic [7:0] r01();
        return {tuning_output_disable, gain_response_select, video_level};
    endfunction
    function automatic logic [7:0] r02();
        return {2'b00, rf_gain_reference};
    endfunction
    // Send a byte and judge the ack slot
    task automatic send(input logic [7:0] b, input logic exp_ack, input string what);
        logic ack;
        tv_if_bus_master_i.put_byte(b, 8, ack);
        check({7'h00, ack}, {7'h00, exp_ack}, what);
    endtask
    // Read the status byte
    task automatic rd(input logic [7:0] exp);
        logic [7:0] b;
        logic       rel;
        tv_if_bus_master_i.bus_start();
        send(SLAVE_ADDR | 8'h01, 1'b1, "read address");
        tv_if_bus_master_i.get_byte(b, rel);
        tv_if_bus_master_i.bus_stop();
        check(b, exp, "status byte");
        check({7'h00, rel}, 8'h01, "line after status");
    endtask
    // **********************
    // Scenarios
    // **********************
    task automatic t_reset_state();
        check({7'h00, power_on_flag}, 8'h01, "power flag");
        check(r00() | r01() | r02(), 8'h00, "controls at reset");
    endtask
    task automatic t_write_all();
        tv_if_bus_master_i.bus_start();
        send(SLAVE_ADDR, 1'b1, "address");
        send(STANDARD_AND_SWITCH_CONTROL, 1'b1, "sub 00");
        send(8'ha5, 1'b1, "data 00");
        send(8'h6b, 1'b1, "data 01");
        send(8'h3c, 1'b1, "data 02");
        tv_if_bus_master_i.bus_stop();
        check(r00(), 8'ha4, "reg 00");
        check(r01(), 8'h6b, "reg 01");
        check(r02(), 8'h3c, "reg 02");
    endtask
    task automatic t_inc_overflow();
        tv_if_bus_master_i.bus_start();
        send(SLAVE_ADDR, 1'b1, "address");
        send(TUNING_GAIN_AND_VIDEO_LEVEL, 1'b1, "sub 01");
        send(8'h94, 1'b1, "data 01");
        send(8'h3f, 1'b1, "data 02");
        send(8'h77, 1'b0, "data past 02");
        tv_if_bus_master_i.bus_stop();
        check(r01(), 8'h94, "reg 01");
        check(r02(), 8'h3f, "reg 02");
        check(r00(), 8'ha4, "reg 00 untouched");
    endtask
    task automatic t_wrong_addr();
        tv_if_bus_master_i.bus_start();
        send(8'ha0, 1'b0, "foreign address");
        send(8'h00, 1'b0, "sub after foreign");
        send(8'h11, 1'b0, "data after foreign");
        tv_if_bus_master_i.bus_stop();
        check(r00(), 8'ha4, "reg 00 kept");
    endtask
    task automatic t_abort();
        logic ack;
        tv_if_bus_master_i.bus_start();
        send(SLAVE_ADDR, 1'b1, "address");
        send(8'h00, 1'b1, "sub 00");
        tv_if_bus_master_i.put_byte(8'h5a, 4, ack);
        tv_if_bus_master_i.bus_stop();
        check(r00(), 8'ha4, "reg 00 after stop");
        tv_if_bus_master_i.bus_start();
        send(SLAVE_ADDR, 1'b1, "address");
        send(8'h00, 1'b1, "sub 00");
        send(8'h5a, 1'b1, "data 00");
        tv_if_bus_master_i.bus_stop();
        check(r00(), 8'h5a, "reg 00 flipped");
    endtask
    task automatic t_read();
        horizontal_unlock_in = 1'b1;
        rd(8'hdf);
        check({7'h00, power_on_flag}, 8'h00, "power flag cleared");
        @(negedge clk);
        horizontal_unlock_in = 1'b0;
        pll_unlock_in = 1'b1;
        rd(8'h3f);
    endtask
    // Main sequence
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (10) @(negedge clk);
        t_reset_state();
        t_write_all();
        t_inc_overflow();
        t_wrong_addr();
        t_abort();
        t_read();
        conclude();
    end
endmodule // tv_if_control_serial_slave_tb
`default_nettype wire
